// ==== dv/accel_z_temp_irq_status_regs_tb_top.sv ====
// Purpose: register level tests of Z data, temperature and event flags
// Assumes: temporary hold shortened to two cycles
// Notes:   sensor side events are driven directly by the bench
`timescale 1ns/1ns
module accel_z_temp_irq_status_regs_tb_top;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, z_sample_valid, temp_valid;
  logic        data_ready_evt, queue_level_evt, fifo_full_level, irq;
  logic        tap_sign_in, slope_sign_in;
  logic [2:0]  tap_axis_in, slope_axis_in;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  logic [7:0]  awaddr, araddr, temp_code, motion_evt;
  logic [11:0] z_sample;
  logic [31:0] wdata, rdata;
  int          n_mismatch, samples_checked, i;

  accel_z_temp_irq_status_regs #(.HOLD_CYCLES(2)) accel_z_temp_irq_status_regs_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .z_sample, .z_sample_valid, .temp_code, .temp_valid, .motion_evt,
    .data_ready_evt, .queue_level_evt, .fifo_full_level, .tap_sign_in, .tap_axis_in,
    .slope_sign_in, .slope_axis_in, .irq);

  axi_host_model axi_host_model_i (
    .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  // 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = accel_regs_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    bit          ok;
    axi_host_model_i.read(a, d, r, ok);
    if (!ok) begin
      n_mismatch++;
      stop_test();
    end
    check("rdata", d, e);
    check("rresp", {30'h0, r}, {30'h0, er});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    bit         ok;
    axi_host_model_i.write(a, d, r, ok);
    if (!ok) begin
      n_mismatch++;
      stop_test();
    end
    check("bresp", {30'h0, r}, {30'h0, accel_regs_pkg::RESP_OKAY});
  endtask : wr

  // one cycle event pulse, then let the flags settle
  task automatic pulse(input logic [7:0] m, input logic dr, input logic ql);
    @(posedge aclk);
    motion_evt <= m;
    data_ready_evt <= dr;
    queue_level_evt <= ql;
    @(posedge aclk);
    motion_evt <= 8'h00;
    data_ready_evt <= 1'b0;
    queue_level_evt <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse

  task automatic zs(input logic [11:0] v);
    @(posedge aclk);
    z_sample <= v;
    z_sample_valid <= 1'b1;
    @(posedge aclk);
    z_sample_valid <= 1'b0;
  endtask : zs

  // main sequence
  initial begin
    {aresetn, z_sample, z_sample_valid, temp_code, temp_valid, motion_evt} = '0;
    {data_ready_evt, queue_level_evt, fifo_full_level, tap_sign_in} = '0;
    {tap_axis_in, slope_sign_in, slope_axis_in} = '0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h40, 32'h0, accel_regs_pkg::RESP_SLVERR);
    rd(8'h1D, 32'h0, accel_regs_pkg::RESP_SLVERR);
    $display("test map done");
    zs(12'hA5C);
    rd(8'h18, 32'hC1);
    zs(12'h3B7);
    rd(8'h1C, 32'hA5);
    rd(8'h1C, 32'h3B);
    rd(8'h18, 32'h71);
    rd(8'h18, 32'h70);
    zs(12'hC4F);
    rd(8'h1C, 32'h3B);
    wr(8'h80, 32'h1);
    rd(8'h18, 32'hF1);
    zs(12'h812);
    rd(8'h1C, 32'h81);
    wr(8'h1C, 32'hFF);
    rd(8'h1C, 32'h81);
    wr(8'h80, 32'h0);
    $display("test z done");
    @(posedge aclk);
    temp_code <= 8'hE7;
    temp_valid <= 1'b1;
    @(posedge aclk);
    temp_valid <= 1'b0;
    rd(8'h20, 32'hE7);
    wr(8'h20, 32'hFF);
    rd(8'h20, 32'hE7);
    $display("test temp done");
    wr(8'h80, 32'h70);
    pulse(8'hFF, 1'b1, 1'b1);
    rd(8'h24, 32'h0);
    rd(8'h28, 32'h0);
    wr(8'h84, 32'h7FF);
    tap_sign_in <= 1'b1;
    tap_axis_in <= 3'b101;
    slope_axis_in <= 3'b010;
    for (i = 0; i < 8; i++) begin
      wr(8'h80, 32'h170);
      pulse(8'h01 << i, 1'b0, 1'b0);
      rd(8'h24, 32'h1 << i);
    end
    rd(8'h2C, 32'hD2);
    tap_sign_in <= 1'b0;
    tap_axis_in <= 3'b011;
    slope_sign_in <= 1'b1;
    slope_axis_in <= 3'b100;
    pulse(8'h10, 1'b0, 1'b0);
    rd(8'h2C, 32'h32);
    pulse(8'h04, 1'b0, 1'b0);
    rd(8'h2C, 32'h3C);
    wr(8'h80, 32'h170);
    pulse(8'h00, 1'b1, 1'b1);
    rd(8'h28, 32'hC0);
    rd(8'h24, 32'h0);
    wr(8'h28, 32'h0);
    rd(8'h28, 32'hC0);
    wr(8'h80, 32'h180);
    rd(8'h28, 32'h0);
    fifo_full_level <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(8'h28, 32'h20);
    fifo_full_level <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(8'h28, 32'h0);
    wr(8'h80, 32'h10);
    pulse(8'h01, 1'b0, 1'b0);
    repeat (10) @(posedge aclk);
    rd(8'h24, 32'h0);
    wr(8'h80, 32'hF0);
    pulse(8'h01, 1'b0, 1'b0);
    repeat (10) @(posedge aclk);
    rd(8'h24, 32'h1);
    $display("test flags done");
    wr(8'h88, 32'h7FF);
    wr(8'h8C, 32'h0);
    rd(8'h88, 32'h0);
    pulse(8'h04, 1'b0, 1'b0);
    check("irq", {31'h0, irq}, 32'h0);
    rd(8'h88, 32'h4);
    wr(8'h8C, 32'h4);
    check("irq", {31'h0, irq}, 32'h1);
    wr(8'h88, 32'h4);
    rd(8'h88, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    $display("test irq done");
    stop_test();
  end
endmodule : accel_z_temp_irq_status_regs_tb_top

// ==== dv/axi_host_model.sv ====
// Purpose: host side model that reaches the register slice over AXI4-Lite
// Assumes: tasks are called from the bench, one at a time
// Notes:   each task gives up after a bounded wait and reports it through ok
`timescale 1ns/1ns
module axi_host_model (
  input  wire logic        aclk,
  output      logic [7:0]  awaddr,
  output      logic        awvalid,
  input  wire logic        awready,
  output      logic [31:0] wdata,
  output      logic [3:0]  wstrb,
  output      logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output      logic        bready,
  output      logic [7:0]  araddr,
  output      logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output      logic        rready
);
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // address and data offered together, each dropped once taken
  task automatic write(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r, output bit ok);
    int n;
    ok = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        ok = 1'b1;
        break;
      end
    end
    bready <= 1'b0;
  endtask : write

  // read address, then answer taken at the edge where rvalid is seen
  task automatic read(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r, output bit ok);
    int n;
    ok = 1'b0;
    d = '0;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        ok = 1'b1;
        break;
      end
    end
    rready <= 1'b0;
  endtask : read
endmodule : axi_host_model

// ==== inc/accel_regs_pkg.sv ====
// Purpose: shared constants for the Z data, temperature and event flag register slice
// Assumes: AXI4-Lite register access, 32-bit data, one register per aligned word
// Notes:   register indices are word indices; byte address is four times the index
package accel_regs_pkg;

  // register indices (byte address = index * 4)
  localparam logic [5:0] IDX_Z_LOW      = 6'h06;
  localparam logic [5:0] IDX_Z_HIGH     = 6'h07;
  localparam logic [5:0] IDX_TEMP       = 6'h08;
  localparam logic [5:0] IDX_MOTION     = 6'h09;
  localparam logic [5:0] IDX_DATA_BUF   = 6'h0A;
  localparam logic [5:0] IDX_ORIGIN     = 6'h0B;
  localparam logic [5:0] IDX_CTRL       = 6'h20;
  localparam logic [5:0] IDX_ENABLE     = 6'h21;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h22;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h23;

  // flag vector layout
  localparam int NUM_FLAGS      = 11;
  localparam int FLAG_STAP      = 5;
  localparam int FLAG_DTAP      = 4;
  localparam int FLAG_SLOPE     = 2;
  localparam int FLAG_FIFO_FULL = 8;
  localparam int FLAG_QUEUE_LVL = 9;
  localparam int FLAG_DATA_RDY  = 10;

  // control register fields
  localparam int CTRL_SHADOW_DIS = 0;
  localparam int CTRL_LATCH_LSB  = 4;
  localparam int CTRL_LATCH_CLR  = 8;

  // z low byte layout
  localparam int ZLOW_NEW_DATA = 0;

  // latch setting codes
  localparam logic [3:0] LATCH_CODE_NONE_A = 4'h0;
  localparam logic [3:0] LATCH_CODE_NONE_B = 4'h8;
  localparam logic [3:0] LATCH_CODE_PERM_A = 4'h7;
  localparam logic [3:0] LATCH_CODE_PERM_B = 4'hF;

  // reset values
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [10:0] RESET_FLAGS = 11'h000;
  localparam logic [3:0]  RESET_LATCH = 4'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {LATCH_NONE, LATCH_TEMP, LATCH_PERM} latch_kind_e;

endpackage : accel_regs_pkg

// ==== src/accel_z_temp_irq_status_regs.sv ====
// Purpose: Z high/low data with read lock, temperature and event flag registers
// Assumes: sensor side inputs come from logic on aclk; host reaches it over AXI4-Lite
// Notes:   flags hold per the latch setting; events also raise a masked interrupt
//
// What this block does
// (R01) Reading Z low byte with shadowing on freezes Z high until it is read.
// (R02) A burst reading low then high gives a consistent sample by itself.
// (R03) Host must not trust Z reads during power-up or deepest sleep state.
// (R04) Z high register carries sample bits 11 to 4.
// (R05) Temperature register holds 8-bit two's complement, zero means 23 C.
// (R06) A flag sets only when its function triggers and is enabled.
// (R07) Latch setting selects permanent, temporary or no holding of flags.
// (R08) Motion flags: flat, orient, single tap, double tap, slow, slope, high, low.
// (R09) Data register bit 7 data ready, bit 6 queue level flag.
// (R10) Data register bit 5 reads 1 while FIFO full is active; here it sets only while enable bit 8 is set.
// (R11) Host treats data register bits 4 to 0 as reserved, writes zero.
// (R12) Origin bit 7 gives tap sign, 0 positive, 1 negative.
// (R13) Origin bits 6 to 4 give tap axis Z, Y, X.
// (R14) Origin bit 3 gives slope sign, 0 positive, 1 negative.
// (R15) Origin bits 2 to 0 give slope axis Z, Y, X.
// (R16) Z low carries sample bits 3 to 0 in 7 to 4; bit 0 new data.
// (R17) Reads leave data unchanged except the lock and the Z low new data bit; writes to read-only registers ignored.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
module accel_z_temp_irq_status_regs #(
  parameter int HOLD_CYCLES = 16  // temporary latch hold time in aclk cycles
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  input  wire logic [11:0] z_sample,
  input  wire logic        z_sample_valid,
  input  wire logic [7:0]  temp_code,
  input  wire logic        temp_valid,
  input  wire logic [7:0]  motion_evt,
  input  wire logic        data_ready_evt,
  input  wire logic        queue_level_evt,
  input  wire logic        fifo_full_level,
  input  wire logic        tap_sign_in,
  input  wire logic [2:0]  tap_axis_in,
  input  wire logic        slope_sign_in,
  input  wire logic [2:0]  slope_axis_in,
  output      logic        irq
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int NF = accel_regs_pkg::NUM_FLAGS;

  generate
    if (HOLD_CYCLES < 1) begin : g_bad_hold
      $error("HOLD_CYCLES must be at least 1");
    end
  endgenerate

  // word index of an aligned address, with a valid mark
  function automatic logic [6:0] word_of(input logic [7:0] addr);
    word_of = {(addr[1:0] == 2'h0), addr[7:2]};
  endfunction : word_of

  function automatic logic is_mapped(input logic [6:0] w);
    logic [5:0] i;
    i = w[5:0];
    is_mapped = w[6] && ((i >= accel_regs_pkg::IDX_Z_LOW && i <= accel_regs_pkg::IDX_ORIGIN)
                || (i >= accel_regs_pkg::IDX_CTRL && i <= accel_regs_pkg::IDX_IRQ_MASK));
  endfunction : is_mapped

  function automatic accel_regs_pkg::latch_kind_e latch_kind(input logic [3:0] code);
    if (code == accel_regs_pkg::LATCH_CODE_NONE_A || code == accel_regs_pkg::LATCH_CODE_NONE_B)
      latch_kind = accel_regs_pkg::LATCH_NONE;
    else if (code == accel_regs_pkg::LATCH_CODE_PERM_A
             || code == accel_regs_pkg::LATCH_CODE_PERM_B)
      latch_kind = accel_regs_pkg::LATCH_PERM;
    else
      latch_kind = accel_regs_pkg::LATCH_TEMP;
  endfunction : latch_kind

  logic [7:0]    aw_addr_q;
  logic          aw_held;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_q;
  logic          w_held;
  logic          do_write;
  logic [6:0]    wr_word;
  logic          rd_fire;
  logic [6:0]    rd_word;
  logic          rd_low;
  logic          rd_high;
  logic [31:0]   next_rdata;
  logic [11:0]   z_live;
  logic          new_data;
  logic [7:0]    z_shadow;
  logic          z_lock;
  logic [7:0]    die_temperature;
  logic          shadow_dis;
  logic [3:0]    latch_mode;
  logic          latch_clr;
  logic [NF-1:0] int_enable;
  logic [NF-1:0] set_vec;
  logic [NF-1:0] flags;
  logic [3:0]    tap_origin;
  logic [3:0]    slope_origin;
  logic [NF-1:0] irq_status;
  logic [NF-1:0] irq_mask;
  logic          wr_hit_low;
  logic          wr_hit_hi;
  accel_regs_pkg::latch_kind_e kind;

  // write channel handshakes; address and data taken in either order
  assign awready  = !aw_held && !bvalid;
  assign wready   = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign wr_word  = word_of(aw_addr_q);
  assign wr_hit_low = do_write && w_strb_q[0];
  assign wr_hit_hi  = do_write && w_strb_q[1];

  // hold write address and data until both are present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= accel_regs_pkg::RESET_BYTE;
      w_held    <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response; unmapped words answer with slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= accel_regs_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= is_mapped(wr_word) ? accel_regs_pkg::RESP_OKAY : accel_regs_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // software writable control, enable and mask; data registers ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_dis <= 1'b0;
      latch_mode <= accel_regs_pkg::RESET_LATCH;
      latch_clr  <= 1'b0;
      int_enable <= accel_regs_pkg::RESET_FLAGS;
      irq_mask   <= accel_regs_pkg::RESET_FLAGS;
    end else begin
      latch_clr <= 1'b0;
      if (wr_word == {1'b1, accel_regs_pkg::IDX_CTRL}) begin
        if (wr_hit_low) begin
          shadow_dis <= w_data_q[accel_regs_pkg::CTRL_SHADOW_DIS];
          latch_mode <= w_data_q[accel_regs_pkg::CTRL_LATCH_LSB +: 4];
        end
        if (wr_hit_hi) begin
          latch_clr <= w_data_q[accel_regs_pkg::CTRL_LATCH_CLR];
        end
      end else if (wr_word == {1'b1, accel_regs_pkg::IDX_ENABLE}) begin
        if (wr_hit_low) int_enable[7:0] <= w_data_q[7:0];
        if (wr_hit_hi) int_enable[NF-1:8] <= w_data_q[NF-1:8];
      end else if (wr_word == {1'b1, accel_regs_pkg::IDX_IRQ_MASK}) begin  // R17
        if (wr_hit_low) irq_mask[7:0] <= w_data_q[7:0];
        if (wr_hit_hi) irq_mask[NF-1:8] <= w_data_q[NF-1:8];
      end
    end
  end

  // read channel: one read at a time, answered the cycle after it is taken
  assign arready = !rvalid;
  assign rd_fire = arvalid && arready;
  assign rd_word = word_of(araddr);
  assign rd_low  = rd_fire && rd_word == {1'b1, accel_regs_pkg::IDX_Z_LOW};
  assign rd_high = rd_fire && rd_word == {1'b1, accel_regs_pkg::IDX_Z_HIGH};

  // read data selection; reserved and upper bits read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_word == {1'b1, accel_regs_pkg::IDX_Z_LOW}) begin
      next_rdata[7:0] = {z_live[3:0], 3'h0, new_data};  // R16
    end else if (rd_word == {1'b1, accel_regs_pkg::IDX_Z_HIGH}) begin
      next_rdata[7:0] = z_lock ? z_shadow : z_live[11:4];  // R04 R01
    end else if (rd_word == {1'b1, accel_regs_pkg::IDX_TEMP}) begin
      next_rdata[7:0] = die_temperature;  // R05
    end else if (rd_word == {1'b1, accel_regs_pkg::IDX_MOTION}) begin
      next_rdata[7:0] = flags[7:0];  // R08
    end else if (rd_word == {1'b1, accel_regs_pkg::IDX_DATA_BUF}) begin
      next_rdata[7:0] = {flags[NF-1:8], 5'h00};  // R09 R10 R11
    end else if (rd_word == {1'b1, accel_regs_pkg::IDX_ORIGIN}) begin
      next_rdata[7:0] = {tap_origin, slope_origin};  // R12 R13 R14 R15
    end else if (rd_word == {1'b1, accel_regs_pkg::IDX_CTRL}) begin
      next_rdata[7:0] = {latch_mode, 3'h0, shadow_dis};
    end else if (rd_word == {1'b1, accel_regs_pkg::IDX_ENABLE}) begin
      next_rdata[NF-1:0] = int_enable;
    end else if (rd_word == {1'b1, accel_regs_pkg::IDX_IRQ_STATUS}) begin
      next_rdata[NF-1:0] = irq_status;
    end else if (rd_word == {1'b1, accel_regs_pkg::IDX_IRQ_MASK}) begin
      next_rdata[NF-1:0] = irq_mask;
    end
  end

  // registered read answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= accel_regs_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= is_mapped(rd_word) ? accel_regs_pkg::RESP_OKAY : accel_regs_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // live Z sample and its new data mark; a fresh sample beats the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      z_live   <= 12'h000;
      new_data <= 1'b0;
    end else begin
      if (z_sample_valid) z_live <= z_sample;
      if (z_sample_valid) new_data <= 1'b1;  // R16
      else if (rd_low) new_data <= 1'b0;
    end
  end

  // high byte lock: low byte read captures, high byte read releases
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      z_shadow <= accel_regs_pkg::RESET_BYTE;
      z_lock   <= 1'b0;
    end else if (rd_low && !shadow_dis) begin
      z_shadow <= z_live[11:4];  // R01 R02
      z_lock   <= 1'b1;
    end else if (rd_high) begin
      z_lock <= 1'b0;  // R01
    end
  end

  // temperature readout
  always_ff @(posedge aclk) begin
    if (!aresetn) die_temperature <= accel_regs_pkg::RESET_BYTE;
    else if (temp_valid) die_temperature <= temp_code;  // R05
  end

  // trigger vector, gated by each function's enable
  assign set_vec = {data_ready_evt, queue_level_evt, fifo_full_level, motion_evt}
                   & int_enable;  // R06
  assign kind = latch_kind(latch_mode);

  // one flag holder per event, behaviour chosen by the latch setting
  generate
    for (genvar i = 0; i < NF; i++) begin : g_flag
      logic [HW-1:0] hold;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flags[i] <= 1'b0;
          hold     <= '0;
        end else if (set_vec[i]) begin
          flags[i] <= 1'b1;  // R06
          hold     <= HW'(HOLD_CYCLES);
        end else begin
          case (kind)  // R07
            accel_regs_pkg::LATCH_NONE: flags[i] <= 1'b0;
            accel_regs_pkg::LATCH_TEMP: begin
              if (hold <= HW'(1)) flags[i] <= 1'b0;
              if (hold != '0) hold <= hold - HW'(1);
            end
            default: if (latch_clr) flags[i] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // tap and slope origin captured with their events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tap_origin   <= 4'h0;
      slope_origin <= 4'h0;
    end else begin
      if (set_vec[accel_regs_pkg::FLAG_STAP] || set_vec[accel_regs_pkg::FLAG_DTAP])
        tap_origin <= {tap_sign_in, tap_axis_in};  // R12 R13
      if (set_vec[accel_regs_pkg::FLAG_SLOPE])
        slope_origin <= {slope_sign_in, slope_axis_in};  // R14 R15
    end
  end

  // sticky interrupt status, write one to clear, new events win
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= accel_regs_pkg::RESET_FLAGS;
    end else begin
      irq_status <= (irq_status & ~((wr_word == {1'b1, accel_regs_pkg::IDX_IRQ_STATUS})
                    ? ({{(NF-8){wr_hit_hi}}, {8{wr_hit_low}}} & w_data_q[NF-1:0])
                    : accel_regs_pkg::RESET_FLAGS)) | set_vec;
    end
  end

  // level interrupt from unmasked status
  assign irq = |(irq_status & irq_mask);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_low_read;
    rd_low && !shadow_dis;
  endsequence
  sequence seq_high_read;
    rd_high;
  endsequence

  AST_LOCK_ON_LOW: assert property (seq_low_read |=> z_lock && z_shadow == $past(z_live[11:4])) // R01
    else $error("low byte read did not lock high byte");
  AST_HIGH_FROM_SHADOW: assert property (seq_high_read ##0 z_lock |=> rdata[7:0] == $past(z_shadow)) // R02
    else $error("locked high byte read gave wrong value");
  AST_UNLOCK: assert property (seq_high_read |=> !z_lock) // R01
    else $error("high byte read did not release lock");
  AST_HIGH_LIVE: assert property (rd_high && !z_lock |=> rdata[7:0] == $past(z_live[11:4])) // R04
    else $error("high byte not sample bits 11 to 4");
  AST_TEMP_READ: assert property (rd_fire && rd_word == {1'b1, accel_regs_pkg::IDX_TEMP} // R05
    |=> rdata[7:0] == $past(die_temperature))
    else $error("temperature read mismatch");
  AST_ENABLE_GATE: assert property (((flags & ~$past(flags)) & ~$past(int_enable)) == '0) // R06
    else $error("flag set while function disabled");
  AST_NO_LATCH: assert property (kind == accel_regs_pkg::LATCH_NONE && set_vec == '0 // R07
    |=> flags == '0)
    else $error("non-latched flag held");
  AST_PERM_HOLD: assert property (kind == accel_regs_pkg::LATCH_PERM && !latch_clr // R07
    |=> (flags & $past(flags)) == $past(flags))
    else $error("permanent flag dropped");
  AST_DATA_REG: assert property (rd_fire && rd_word == {1'b1, accel_regs_pkg::IDX_DATA_BUF} // R10
    |=> rdata[7:0] == {$past(flags[NF-1:8]), 5'h00})
    else $error("data register layout wrong");
  AST_TAP_ORIGIN: assert property (set_vec[accel_regs_pkg::FLAG_STAP] // R13
    |=> tap_origin == {$past(tap_sign_in), $past(tap_axis_in)})
    else $error("tap origin not captured");
  AST_NEW_DATA: assert property (z_sample_valid |=> new_data ##0 z_live == $past(z_sample)) // R16
    else $error("new sample not marked");
  AST_SET_WINS: assert property (1'b1 |=> (irq_status & $past(set_vec)) == $past(set_vec))
    else $error("event lost against clear");

endmodule : accel_z_temp_irq_status_regs
